// File: shared/plpmc_map.svh
`ifndef PLPMC_MAP_SVH
`define PLPMC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PLPMC_OFF_RIS 12'h050
`define PLPMC_OFF_IMC 12'h054
`define PLPMC_OFF_MISC 12'h058
`define PLPMC_OFF_RESET_CAUSE_REG 12'h05c
`define PLPMC_OFF_RCC 12'h060
`define PLPMC_OFF_PLLCFG 12'h064
`define PLPMC_OFF_CLOCK_CONFIG_EXT_REG 12'h070
`define PLPMC_OFF_MAIN_OSC_CONTROL_REG 12'h07c
`define PLPMC_OFF_RGATE 12'h100
`define PLPMC_OFF_SGATE 12'h110
`define PLPMC_OFF_DGATE 12'h120
`define PLPMC_OFF_DSCFG 12'h144

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PLPMC_CFG_MAIN_OSC_DIS 0
`define PLPMC_CFG_INTERNAL_OSC_DIS 1
`define PLPMC_CFG_OSC_SOURCE_SELECT 5:4
`define PLPMC_CFG_CRYSTAL_SELECT 10:6
`define PLPMC_CFG_BYPASS 11
`define PLPMC_CFG_PLL_POWER_OFF 13
`define PLPMC_CFG_APPLY_DIVIDER 22
`define PLPMC_CFG_SYSCLK_DIVIDER 26:23
`define PLPMC_CFG_ACG 27
`define PLPMC_EXT_USE 31
`define PLPMC_EXT_SYSCLK_DIVIDER 28:23
`define PLPMC_EXT_USBPWRDN 14
`define PLPMC_EXT_PLL_POWER_OFF 13
`define PLPMC_EXT_BYPASS 11
`define PLPMC_EXT_OSC_SOURCE_SELECT 6:4
`define PLPMC_DS_OSC 6:4
`define PLPMC_RIS_PLL 6
`define PLPMC_RIS_USB 7
`define PLPMC_RESET_CAUSE_REG_OSCFAIL 16
`define PLPMC_MAIN_OSC_CHECK 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PLPMC_RST_RCC 32'h07803ad1
`define PLPMC_RST_CLOCK_CONFIG_EXT_REG 32'h07806810
`define PLPMC_RST_DSCFG 32'h07800000
`define PLPMC_RST_GATE0 32'h00000040
`define PLPMC_RST_ZERO 32'h00000000

// ----------------------------------------------------------------------------
// Timing and counts
// ----------------------------------------------------------------------------
`define PLPMC_LOCK_LOAD 14'h1200
`define PLPMC_LOCK_LOAD_HI 14'h2400
`define PLPMC_CRYSTAL_SELECT_HI_LIMIT 5'h0f
`define PLPMC_FAIL_RST_PERIODS 6'h20
`define PLPMC_DS_DIV16 6'h0f
`define PLPMC_DS_DIV64 6'h3f
`define PLPMC_CLK_PERIOD_NS 25
`define PLPMC_OSC_WIN_NS 25600
`define PLPMC_OSC_WIN_CYC (`PLPMC_OSC_WIN_NS / `PLPMC_CLK_PERIOD_NS)

`endif

// File: shared/plpmc_pkg.sv
package plpmc_pkg;

  typedef enum logic [2:0] {
    SRC_MAIN = 3'h0,
    SRC_INTERNAL_OSC = 3'h1,
    SRC_IOSC4 = 3'h2,
    SRC_LF = 3'h3,
    SRC_PLL = 3'h4
  } plpmc_src_e;

  typedef enum logic [1:0] {
    M_RUN = 2'h0,
    M_SLEEP = 2'h1,
    M_DEEP = 2'h3,
    M_WAKE = 2'h2
  } plpmc_mode_e;

  typedef enum logic [1:0] {
    F_IDLE = 2'h0,
    F_SWITCH = 2'h1,
    F_RESET = 2'h3,
    F_NMI = 2'h2
  } plpmc_fail_e;

endpackage

// File: verilog/plpmc_top.sv
// Functional notes
// [RULE_01] Changed crystal select restarts relock; same value not
// [RULE_02] Any PLL power-up restarts its relock
// [RULE_03] Lock counter loads 0x1200, counts main oscillator
// [RULE_04] Crystal select above 0x0f loads 0x2400
// [RULE_05] Main PLL never system clock before lock
// [RULE_06] Enable-and-select together: stay on oscillator until lock
// [RULE_07] Main lock sets raw flag and interrupt
// [RULE_08] USB PLL ungated; raw flag and interrupt only
// [RULE_09] Frequency checker runs when enabled, flags band errors
// [RULE_10] Oscillator error: flag, enable internal, switch to it
// [RULE_11] Then 32 internal periods reset, then NMI
// [RULE_12] Sleep: stop processor, sleep or run gating
// [RULE_13] Sleep keeps run source and divider
// [RULE_14] Deep-sleep: stop processor, deep or run gating
// [RULE_15] Deep-sleep source: main, or chosen internal oscillator
// [RULE_16] Running PLL: power down, divider /16 or /64
// [RULE_17] Exit restores clock first, then enables clocks
// [RULE_18] Sleep only on request; interrupt wakes
// [RULE_19] Extended select takes fields from extended register
// [RULE_20] Crystal write loads translation; power bit enables PLL
// [RULE_21] Software orders bypass, program, divide, poll, unbypass
// [RULE_22] Software keeps a stable source before selecting PLL
// [RULE_23] Retrigger during count reloads and clears lock
//
// Decided for this implementation: strobed register access and the register offsets.
`include "plpmc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module plpmc_top import plpmc_pkg::*; #(
  parameter int OSC_MIN_EDGES = 20,
  parameter int OSC_MAX_EDGES = 440
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic main_osc_pin,
  input wire logic int_osc_pin,
  input wire logic wfi_req,
  input wire logic deep_sleep_req,
  input wire logic wake_irq,
  output logic cpu_clk_en,
  output logic [95:0] periph_clk_en,
  output logic [2:0] sysclk_src,
  output logic [5:0] sysclk_div,
  output logic sysclk_div_use,
  output logic main_pll_power_on,
  output logic usb_pll_power_on,
  output logic main_osc_power_on,
  output logic int_osc_power_on,
  output logic main_pll_locked,
  output logic usb_pll_locked,
  output logic pll_irq,
  output logic sys_reset,
  output logic nmi_req
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [13:0] lock_load(input logic [4:0] crystal_select);
    return (crystal_select > `PLPMC_CRYSTAL_SELECT_HI_LIMIT) ? `PLPMC_LOCK_LOAD_HI : `PLPMC_LOCK_LOAD;
  endfunction

  function automatic plpmc_src_e src_of(input logic [2:0] code);
    case (code)
      3'h0: return SRC_MAIN;
      3'h1: return SRC_INTERNAL_OSC;
      3'h2: return SRC_IOSC4;
      default: return SRC_LF;
    endcase
  endfunction

  function automatic plpmc_src_e ds_src_of(input logic [2:0] code);
    case (code)
      3'h1: return SRC_INTERNAL_OSC;
      3'h3: return SRC_LF;
      default: return SRC_MAIN;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic main_osc_s1_q, main_osc_s2_q, main_osc_s3_q, internal_osc_s1_q, internal_osc_s2_q, internal_osc_s3_q;
  logic main_osc_edge, internal_osc_edge;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {main_osc_s1_q, main_osc_s2_q, main_osc_s3_q} <= 3'h0;
      {internal_osc_s1_q, internal_osc_s2_q, internal_osc_s3_q} <= 3'h0;
    end else begin
      {main_osc_s1_q, main_osc_s2_q, main_osc_s3_q} <= {main_osc_pin, main_osc_s1_q, main_osc_s2_q};
      {internal_osc_s1_q, internal_osc_s2_q, internal_osc_s3_q} <= {int_osc_pin, internal_osc_s1_q, internal_osc_s2_q};
    end
  end

  assign main_osc_edge = main_osc_s2_q && !main_osc_s3_q;
  assign internal_osc_edge = internal_osc_s2_q && !internal_osc_s3_q;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [31:0] rcc_q, rcc_d, clock_config_ext_reg_q, clock_config_ext_reg_d, dscfg_q, dscfg_d, imc_q, imc_d;
  logic [31:0] pllcfg_q, pllcfg_d;
  logic check_en_q, check_en_d;
  logic [31:0] rgate_q [3], rgate_d [3], sgate_q [3], sgate_d [3];
  logic [31:0] dgate_q [3], dgate_d [3];
  logic wr_rcc, crystal_select_chg, use_ext, eff_bypass, eff_pll_power_off;
  logic [4:0] crystal_select_new;
  logic [5:0] eff_div;
  plpmc_src_e eff_src;

  assign wr_rcc = reg_wr && (reg_addr == `PLPMC_OFF_RCC);
  assign crystal_select_new = wr_rcc ? reg_wdata[`PLPMC_CFG_CRYSTAL_SELECT] : rcc_q[`PLPMC_CFG_CRYSTAL_SELECT];
  assign crystal_select_chg = wr_rcc && (reg_wdata[`PLPMC_CFG_CRYSTAL_SELECT] != rcc_q[`PLPMC_CFG_CRYSTAL_SELECT]); // see [RULE_01]
  assign use_ext = clock_config_ext_reg_q[`PLPMC_EXT_USE];
  // The extended register only overrides when selected. // see [RULE_19]
  assign eff_bypass = use_ext ? clock_config_ext_reg_q[`PLPMC_EXT_BYPASS] : rcc_q[`PLPMC_CFG_BYPASS];
  assign eff_pll_power_off = use_ext ? clock_config_ext_reg_q[`PLPMC_EXT_PLL_POWER_OFF] : rcc_q[`PLPMC_CFG_PLL_POWER_OFF];
  assign eff_div = use_ext ? clock_config_ext_reg_q[`PLPMC_EXT_SYSCLK_DIVIDER] : {2'h0, rcc_q[`PLPMC_CFG_SYSCLK_DIVIDER]};
  assign eff_src = use_ext ? src_of(clock_config_ext_reg_q[`PLPMC_EXT_OSC_SOURCE_SELECT])
                           : src_of({1'b0, rcc_q[`PLPMC_CFG_OSC_SOURCE_SELECT]});

  always_comb begin
    rcc_d = rcc_q;
    clock_config_ext_reg_d = clock_config_ext_reg_q;
    dscfg_d = dscfg_q;
    imc_d = imc_q;
    check_en_d = check_en_q;
    pllcfg_d = pllcfg_q;
    rgate_d = rgate_q;
    sgate_d = sgate_q;
    dgate_d = dgate_q;
    if (reg_wr) begin
      case (reg_addr)
        `PLPMC_OFF_RCC: rcc_d = reg_wdata;
        `PLPMC_OFF_CLOCK_CONFIG_EXT_REG: clock_config_ext_reg_d = reg_wdata;
        `PLPMC_OFF_DSCFG: dscfg_d = reg_wdata;
        `PLPMC_OFF_IMC: imc_d = reg_wdata;
        `PLPMC_OFF_MAIN_OSC_CONTROL_REG: check_en_d = reg_wdata[`PLPMC_MAIN_OSC_CHECK];
        default: ;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == 12'(`PLPMC_OFF_RGATE + 4 * i)) rgate_d[i] = reg_wdata;
        if (reg_addr == 12'(`PLPMC_OFF_SGATE + 4 * i)) sgate_d[i] = reg_wdata;
        if (reg_addr == 12'(`PLPMC_OFF_DGATE + 4 * i)) dgate_d[i] = reg_wdata;
      end
    end
    // The PLL translation follows every crystal write automatically. // see [RULE_20]
    if (wr_rcc) pllcfg_d = {27'h0, reg_wdata[`PLPMC_CFG_CRYSTAL_SELECT]};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rcc_q <= `PLPMC_RST_RCC;
      clock_config_ext_reg_q <= `PLPMC_RST_CLOCK_CONFIG_EXT_REG;
      dscfg_q <= `PLPMC_RST_DSCFG;
      imc_q <= `PLPMC_RST_ZERO;
      check_en_q <= 1'b0;
      pllcfg_q <= `PLPMC_RST_ZERO;
      for (int i = 0; i < 3; i++) begin
        rgate_q[i] <= (i == 0) ? `PLPMC_RST_GATE0 : `PLPMC_RST_ZERO;
        sgate_q[i] <= (i == 0) ? `PLPMC_RST_GATE0 : `PLPMC_RST_ZERO;
        dgate_q[i] <= (i == 0) ? `PLPMC_RST_GATE0 : `PLPMC_RST_ZERO;
      end
    end else begin
      rcc_q <= rcc_d;
      clock_config_ext_reg_q <= clock_config_ext_reg_d;
      dscfg_q <= dscfg_d;
      imc_q <= imc_d;
      check_en_q <= check_en_d;
      pllcfg_q <= pllcfg_d;
      rgate_q <= rgate_d;
      sgate_q <= sgate_d;
      dgate_q <= dgate_d;
    end
  end

  // --------------------------------------------------------------------------
  // Power mode
  // --------------------------------------------------------------------------
  plpmc_mode_e mode_q, mode_d;
  logic pll_run_q, pll_run_d, deep_pll_off;
  logic [1:0] pll_on;

  always_comb begin
    mode_d = mode_q;
    pll_run_d = pll_run_q;
    unique case (mode_q)
      M_RUN: if (wfi_req) begin // see [RULE_18]
        mode_d = deep_sleep_req ? M_DEEP : M_SLEEP;
        pll_run_d = !eff_pll_power_off;
      end
      M_SLEEP: if (wake_irq) mode_d = M_RUN; // see [RULE_18]
      M_DEEP: if (wake_irq) mode_d = M_WAKE;
      M_WAKE: mode_d = M_RUN; // see [RULE_17]
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_q <= M_RUN;
      pll_run_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      pll_run_q <= pll_run_d;
    end
  end

  assign deep_pll_off = (mode_q == M_DEEP) && pll_run_q; // see [RULE_16]
  assign pll_on[0] = !eff_pll_power_off && !deep_pll_off;
  assign pll_on[1] = !clock_config_ext_reg_q[`PLPMC_EXT_USBPWRDN] && !deep_pll_off;

  // --------------------------------------------------------------------------
  // Lock counters, index 0 main PLL, index 1 USB PLL
  // --------------------------------------------------------------------------
  logic [1:0] pll_on_q, lock_q, lock_d, trig;
  logic [13:0] cnt_q [2], cnt_d [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      trig[i] = crystal_select_chg || (pll_on[i] && !pll_on_q[i]); // see [RULE_01] [RULE_02]
      cnt_d[i] = cnt_q[i];
      lock_d[i] = lock_q[i];
      if (!pll_on[i]) begin
        cnt_d[i] = 14'h0;
        lock_d[i] = 1'b0;
      end else if (trig[i]) begin
        cnt_d[i] = lock_load(crystal_select_new); // see [RULE_03] [RULE_04] [RULE_23]
        lock_d[i] = 1'b0;
      end else if (main_osc_edge && (cnt_q[i] != 14'h0)) begin
        cnt_d[i] = cnt_q[i] - 14'h1; // see [RULE_03]
        if (cnt_q[i] == 14'h1) lock_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pll_on_q <= 2'h0;
      lock_q <= 2'h0;
      cnt_q[0] <= 14'h0;
      cnt_q[1] <= 14'h0;
    end else begin
      pll_on_q <= pll_on;
      lock_q <= lock_d;
      cnt_q <= cnt_d;
    end
  end

  assign main_pll_locked = lock_q[0];
  assign usb_pll_locked = lock_q[1]; // see [RULE_08]

  // --------------------------------------------------------------------------
  // Oscillator checker and failure sequence
  // --------------------------------------------------------------------------
  plpmc_fail_e fail_q, fail_d;
  logic [9:0] win_q, win_d;
  logic [8:0] edges_q, edges_d;
  logic [5:0] rst_cnt_q, rst_cnt_d;
  logic fail_src_q, fail_src_d, osc_err;
  logic cfg_wr;

  assign cfg_wr = wr_rcc || (reg_wr && (reg_addr == `PLPMC_OFF_CLOCK_CONFIG_EXT_REG));
  assign osc_err = check_en_q && (win_q == 10'(`PLPMC_OSC_WIN_CYC - 1)) &&
                   ((int'(edges_q) < OSC_MIN_EDGES) || (int'(edges_q) > OSC_MAX_EDGES));

  always_comb begin
    win_d = 10'h0;
    edges_d = 9'h0;
    if (check_en_q && (fail_q == F_IDLE) && (win_q != 10'(`PLPMC_OSC_WIN_CYC - 1))) begin
      win_d = win_q + 10'h1; // see [RULE_09]
      edges_d = (main_osc_edge && (edges_q != 9'h1ff)) ? edges_q + 9'h1 : edges_q;
    end
    fail_d = fail_q;
    rst_cnt_d = rst_cnt_q;
    fail_src_d = fail_src_q && !cfg_wr;
    unique case (fail_q)
      F_IDLE: if (osc_err) fail_d = F_SWITCH; // see [RULE_09]
      F_SWITCH: begin
        fail_src_d = 1'b1; // see [RULE_10]
        rst_cnt_d = 6'h0;
        fail_d = F_RESET;
      end
      F_RESET: begin
        fail_src_d = 1'b1;
        if (internal_osc_edge) rst_cnt_d = rst_cnt_q + 6'h1;
        if (internal_osc_edge && (rst_cnt_q == `PLPMC_FAIL_RST_PERIODS - 6'h1)) fail_d = F_NMI; // see [RULE_11]
      end
      F_NMI: fail_d = F_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fail_q <= F_IDLE;
      win_q <= 10'h0;
      edges_q <= 9'h0;
      rst_cnt_q <= 6'h0;
      fail_src_q <= 1'b0;
    end else begin
      fail_q <= fail_d;
      win_q <= win_d;
      edges_q <= edges_d;
      rst_cnt_q <= rst_cnt_d;
      fail_src_q <= fail_src_d;
    end
  end

  assign sys_reset = (fail_q == F_RESET); // see [RULE_11]
  assign nmi_req = (fail_q == F_NMI); // see [RULE_11]

  // --------------------------------------------------------------------------
  // Status, system clock and gating outputs
  // --------------------------------------------------------------------------
  logic [31:0] ris_q, ris_d, reset_cause_reg_q, reset_cause_reg_d, rdata_q, rdata_d;
  logic [95:0] gate_q, gate_d;
  plpmc_src_e src_q, src_d;
  logic [5:0] div_q, div_d;
  logic div_use_q, div_use_d, cpu_en_q, cpu_en_d, ds_int;

  assign ds_int = (mode_q == M_DEEP) && (ds_src_of(dscfg_q[`PLPMC_DS_OSC]) != SRC_MAIN);

  always_comb begin
    // Set wins over a same-cycle clear on every hardware flag.
    ris_d = ris_q;
    reset_cause_reg_d = reset_cause_reg_q;
    if (reg_wr && (reg_addr == `PLPMC_OFF_MISC)) ris_d = ris_q & ~(reg_wdata & imc_q);
    if (reg_wr && (reg_addr == `PLPMC_OFF_RESET_CAUSE_REG)) reset_cause_reg_d = reg_wdata;
    if (lock_d[0] && !lock_q[0]) ris_d[`PLPMC_RIS_PLL] = 1'b1; // see [RULE_07]
    if (lock_d[1] && !lock_q[1]) ris_d[`PLPMC_RIS_USB] = 1'b1; // see [RULE_08]
    if (fail_q == F_SWITCH) reset_cause_reg_d[`PLPMC_RESET_CAUSE_REG_OSCFAIL] = 1'b1; // see [RULE_10]
    src_d = eff_src; // see [RULE_13]
    div_d = eff_div;
    div_use_d = rcc_q[`PLPMC_CFG_APPLY_DIVIDER];
    if (fail_src_q || (fail_q == F_SWITCH)) begin
      src_d = SRC_INTERNAL_OSC; // see [RULE_10]
    end else if (mode_q == M_DEEP) begin
      src_d = ds_src_of(dscfg_q[`PLPMC_DS_OSC]); // see [RULE_15]
      if (pll_run_q) begin
        div_d = use_ext ? `PLPMC_DS_DIV64 : `PLPMC_DS_DIV16; // see [RULE_16]
        div_use_d = 1'b1;
      end
    end else if (!eff_bypass && pll_on[0] && lock_d[0]) begin
      src_d = SRC_PLL; // see [RULE_05] [RULE_06]
    end
    // Wake keeps the processor clock stopped for one cycle while the source is restored; peripherals keep deep-sleep gating.
    cpu_en_d = (mode_d == M_RUN) && (mode_q != M_DEEP); // see [RULE_12] [RULE_14] [RULE_17]
    unique case (mode_d)
      M_SLEEP: gate_d = rcc_q[`PLPMC_CFG_ACG] ? {sgate_q[2], sgate_q[1], sgate_q[0]}
                                              : {rgate_q[2], rgate_q[1], rgate_q[0]}; // see [RULE_12]
      M_DEEP, M_WAKE: gate_d = rcc_q[`PLPMC_CFG_ACG] ? {dgate_q[2], dgate_q[1], dgate_q[0]}
                                                     : {rgate_q[2], rgate_q[1], rgate_q[0]}; // see [RULE_14]
      M_RUN: gate_d = (mode_q == M_DEEP) ? gate_q : {rgate_q[2], rgate_q[1], rgate_q[0]};
    endcase
    rdata_d = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `PLPMC_OFF_RIS: rdata_d = ris_q;
        `PLPMC_OFF_IMC: rdata_d = imc_q;
        `PLPMC_OFF_MISC: rdata_d = ris_q & imc_q;
        `PLPMC_OFF_RESET_CAUSE_REG: rdata_d = reset_cause_reg_q;
        `PLPMC_OFF_RCC: rdata_d = rcc_q;
        `PLPMC_OFF_PLLCFG: rdata_d = pllcfg_q;
        `PLPMC_OFF_CLOCK_CONFIG_EXT_REG: rdata_d = clock_config_ext_reg_q;
        `PLPMC_OFF_MAIN_OSC_CONTROL_REG: rdata_d = {31'h0, check_en_q};
        `PLPMC_OFF_DSCFG: rdata_d = dscfg_q;
        default: ;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == 12'(`PLPMC_OFF_RGATE + 4 * i)) rdata_d = rgate_q[i];
        if (reg_addr == 12'(`PLPMC_OFF_SGATE + 4 * i)) rdata_d = sgate_q[i];
        if (reg_addr == 12'(`PLPMC_OFF_DGATE + 4 * i)) rdata_d = dgate_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ris_q <= `PLPMC_RST_ZERO;
      reset_cause_reg_q <= `PLPMC_RST_ZERO;
      src_q <= SRC_INTERNAL_OSC;
      div_q <= 6'h0;
      div_use_q <= 1'b0;
      cpu_en_q <= 1'b1;
      gate_q <= {`PLPMC_RST_ZERO, `PLPMC_RST_ZERO, `PLPMC_RST_GATE0};
      rdata_q <= 32'h0;
    end else begin
      ris_q <= ris_d;
      reset_cause_reg_q <= reset_cause_reg_d;
      src_q <= src_d;
      div_q <= div_d;
      div_use_q <= div_use_d;
      cpu_en_q <= cpu_en_d;
      gate_q <= gate_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign sysclk_src = src_q;
  assign sysclk_div = div_q;
  assign sysclk_div_use = div_use_q;
  assign cpu_clk_en = cpu_en_q;
  assign periph_clk_en = gate_q;
  assign pll_irq = |(ris_q & imc_q); // see [RULE_07] [RULE_08]
  assign main_pll_power_on = pll_on[0]; // see [RULE_20]
  assign usb_pll_power_on = pll_on[1];
  assign main_osc_power_on = !rcc_q[`PLPMC_CFG_MAIN_OSC_DIS] && !ds_int; // see [RULE_15]
  assign int_osc_power_on = !rcc_q[`PLPMC_CFG_INTERNAL_OSC_DIS] || fail_src_q ||
                            (fail_q != F_IDLE) || ds_int; // see [RULE_10] [RULE_15]

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_fail_reset;
    sys_reset && (sysclk_src == SRC_INTERNAL_OSC) && reset_cause_reg_q[`PLPMC_RESET_CAUSE_REG_OSCFAIL];
  endsequence
  sequence s_nmi_then_idle;
    nmi_req ##1 !nmi_req && !sys_reset;
  endsequence

  property p_crystal_select_relock;
    (crystal_select_chg && pll_on[0]) |=> !main_pll_locked && (cnt_q[0] == lock_load($past(crystal_select_new)));
  endproperty
  a_crystal_select_relock: assert property (p_crystal_select_relock) else $error("no relock on crystal change"); // see [RULE_01]

  property p_same_crystal_select;
    (wr_rcc && (reg_wdata == rcc_q) && main_pll_locked && (mode_q == M_RUN) && !wfi_req)
      |=> main_pll_locked;
  endproperty
  a_same_crystal_select: assert property (p_same_crystal_select) else $error("relock on unchanged crystal"); // see [RULE_01]

  property p_powerup_load;
    (pll_on[0] && !pll_on_q[0]) |=> (cnt_q[0] == $past(lock_load(rcc_q[`PLPMC_CFG_CRYSTAL_SELECT])));
  endproperty
  a_powerup_load: assert property (p_powerup_load) else $error("power-up load wrong"); // see [RULE_02]

  property p_pll_gated;
    (sysclk_src == SRC_PLL) |-> main_pll_locked;
  endproperty
  a_pll_gated: assert property (p_pll_gated) else $error("PLL used before lock"); // see [RULE_05]

  property p_lock_flag;
    $rose(main_pll_locked) |-> ris_q[`PLPMC_RIS_PLL] ##1 (pll_irq || !imc_q[`PLPMC_RIS_PLL]);
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lock flag not set"); // see [RULE_07]

  property p_fail_seq;
    (fail_q == F_SWITCH) |=> s_fail_reset;
  endproperty
  a_fail_seq: assert property (p_fail_seq) else $error("fail sequence broken"); // see [RULE_10]

  property p_fail_nmi;
    $fell(sys_reset) |-> s_nmi_then_idle and (rst_cnt_q == `PLPMC_FAIL_RST_PERIODS);
  endproperty
  a_fail_nmi: assert property (p_fail_nmi) else $error("reset length or NMI wrong"); // see [RULE_11]

  property p_sleep_cpu_off;
    (mode_q inside {M_SLEEP, M_DEEP}) |-> !cpu_clk_en;
  endproperty
  a_sleep_cpu_off: assert property (p_sleep_cpu_off) else $error("processor clocked in sleep"); // see [RULE_12]

  property p_deep_pll_off;
    ((mode_q == M_DEEP) && pll_run_q) |-> !main_pll_power_on ##1 sysclk_div_use;
  endproperty
  a_deep_pll_off: assert property (p_deep_pll_off) else $error("PLL kept in deep-sleep"); // see [RULE_16]

  property p_wake_order;
    (mode_q == M_WAKE) |-> !cpu_clk_en ##1 (cpu_clk_en && (sysclk_div == $past(eff_div)));
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("clocks enabled before restore"); // see [RULE_17]

endmodule // plpmc_top

`default_nettype wire

// File: testbench/test_pll_lock_and_power_mode_clocking.sv
`timescale 1ns/1ps
`default_nettype none
module test_pll_lock_and_power_mode_clocking import plpmc_pkg::*; ;
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, osc_run = 1'b1;
  logic main_osc_pin = 1'b0, int_osc_pin = 1'b0, wfi_req = 1'b0, deep_sleep_req = 1'b0;
  logic wake_irq = 1'b0, cpu_clk_en, sysclk_div_use, main_pll_power_on, usb_pll_power_on;
  logic main_osc_power_on, int_osc_power_on, main_pll_locked, usb_pll_locked;
  logic pll_irq, sys_reset, nmi_req;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, g, seed = 32'h1b8f;
  logic [95:0] periph_clk_en;
  logic [2:0] sysclk_src;
  logic [5:0] sysclk_div;
  logic [1:0] ph = 2'h0;
  int err_total = 0, cmp_count = 0, n;

  // ----------------------------------------------------------------
  // Clock, oscillators and helpers
  // ----------------------------------------------------------------
  // Both oscillators run at a quarter of the bus clock so lock counts stay short.
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    main_osc_pin <= osc_run & ph[1];
    int_osc_pin <= ph[1];
  end

  plpmc_top i_plpmc_top (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .main_osc_pin, .int_osc_pin, .wfi_req, .deep_sleep_req, .wake_irq,
    .cpu_clk_en, .periph_clk_en, .sysclk_src, .sysclk_div, .sysclk_div_use,
    .main_pll_power_on, .usb_pll_power_on, .main_osc_power_on, .int_osc_power_on,
    .main_pll_locked, .usb_pll_locked, .pll_irq, .sys_reset, .nmi_req);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task sleep_in(input logic ds);
    @(posedge ref_clk);
    wfi_req <= 1'b1;
    deep_sleep_req <= ds;
    @(posedge ref_clk);
    wfi_req <= 1'b0;
    cyc(3);
  endtask
  // Clocks must come back only once the source is already restored.
  // A deep-sleep exit powers the PLL up again, so it relocks on the oscillator first.
  task wake(input logic [2:0] es);
    @(posedge ref_clk);
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    for (n = 0; n < 8; n++) begin
      cyc(1);
      if (cpu_clk_en === 1'b1) chk(sysclk_src, es);
    end
    chk(cpu_clk_en, 1);
  endtask
  task done(input string s);
    $display("test %s finished, mismatches so far %0d", s, err_total);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    report_and_stop;
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rd(12'h060, 32'h07803ad1);
    rd(12'h070, 32'h07806810);
    rd(12'h100, 32'h00000040);
    rd(12'h144, 32'h07800000);
    rd(12'h200, 32'h0);
    done("reset");
    wr(12'h070, 32'h07802810);
    chk(usb_pll_power_on, 1);
    wr(12'h060, 32'h01c00380);
    cyc(16384);
    chk(main_pll_locked, 0);
    chk(sysclk_src == SRC_PLL, 0);
    wr(12'h060, 32'h01c00400);
    for (n = 0; n < 40000 && main_pll_locked !== 1'b1; n++) begin
      cyc(1);
      if (sysclk_src === SRC_PLL) chk(main_pll_locked, 1);
    end
    chk(n > 36840 && n < 36900, 1);
    cyc(4);
    chk(sysclk_src, SRC_PLL);
    chk(usb_pll_locked, 1);
    rd(12'h050, 32'h000000c0);
    wr(12'h060, 32'h01c00400);
    cyc(3);
    chk(main_pll_locked, 1);
    wr(12'h054, 32'h00000040);
    chk(pll_irq, 1);
    wr(12'h058, 32'h00000040);
    rd(12'h050, 32'h00000080);
    done("lock");
    g = xs();
    wr(12'h100, g);
    chk(cpu_clk_en, 1);
    sleep_in(1'b0);
    chk(cpu_clk_en, 0);
    chk(periph_clk_en[31:0], g);
    chk(sysclk_src, SRC_PLL);
    wake(SRC_PLL);
    g = xs();
    wr(12'h120, g);
    wr(12'h060, 32'h09c00400);
    sleep_in(1'b1);
    chk(periph_clk_en[31:0], g);
    chk(sysclk_src, SRC_MAIN);
    chk(main_pll_power_on, 0);
    chk(sysclk_div, 6'h0f);
    chk(sysclk_div_use, 1);
    wake(SRC_MAIN);
    wr(12'h144, 32'h07800010);
    sleep_in(1'b1);
    chk(sysclk_src, SRC_INTERNAL_OSC);
    chk({main_osc_power_on, int_osc_power_on}, 2'b01);
    wake(SRC_MAIN);
    g = xs();
    wr(12'h110, g);
    sleep_in(1'b0);
    chk(periph_clk_en[31:0], g);
    chk(sysclk_src, SRC_MAIN);
    wake(SRC_MAIN);
    done("power modes");
    wr(12'h07c, 32'h00000001);
    osc_run <= 1'b0;
    for (n = 0; n < 3000 && sys_reset !== 1'b1; n++) cyc(1);
    chk(n < 2100, 1);
    chk(sysclk_src, SRC_INTERNAL_OSC);
    chk(int_osc_power_on, 1);
    for (n = 0; n < 400 && sys_reset === 1'b1; n++) cyc(1);
    chk(n >= 120 && n <= 140, 1);
    for (n = 0; n < 4 && nmi_req !== 1'b1; n++) cyc(1);
    chk(nmi_req, 1);
    rd(12'h05c, 32'h00010000);
    done("osc fail");
    report_and_stop;
  end
endmodule // test_pll_lock_and_power_mode_clocking
`default_nettype wire
